// ### src/imr_params.svh
// constants of the i2c master restart and arbitration block
// assumes a 32-bit register port, byte offsets, one word per register
`ifndef IMR_PARAMS_SVH
`define IMR_PARAMS_SVH
// register byte offsets
`define IMR_OFF_CTRL      8'h00
`define IMR_OFF_STAT      8'h04
`define IMR_OFF_TXBUF     8'h08
`define IMR_OFF_BAUD      8'h0c
`define IMR_OFF_RXBUF     8'h10
// control register fields
`define IMR_CTL_START     0
`define IMR_CTL_RESTART   1
`define IMR_CTL_STOP      2
`define IMR_CTL_RECV      3
`define IMR_CTL_ACK       4
`define IMR_CTL_ACKDATA   5
`define IMR_EV_W          5
// status register fields
`define IMR_ST_TBF        0
`define IMR_ST_START      3
`define IMR_ST_STOP       4
`define IMR_ST_WCOL       7
`define IMR_ST_COLL       10
`define IMR_ST_TRANSMIT_IN_PROGRESS     14
`define IMR_ST_ACKSTAT    15
// widths and reset values
`define IMR_BAUD_W        9
`define IMR_BAUD_RST      9'h0ff
`define IMR_BIT_LAST_TX   4'h8
`define IMR_BIT_LAST_DATA 4'h7
`endif

// ### src/imr_pkg.sv
// types of the i2c master restart and arbitration block
// assumes imr_params.svh is on the include path
`include "imr_params.svh"
package imr_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_RS_LO, S_HI_CHK, S_SDA_LO, S_P_LO, S_P_HI, S_P_END,
    S_A_LO, S_A_HI, S_D_LO, S_D_HI
  } imr_state_e;

  typedef struct packed {
    logic [1:0]             scl_sync;
    logic [1:0]             sda_sync;
    logic                   sda_prev;
    imr_state_e             state;
    logic                   seen;
    logic [`IMR_BAUD_W-1:0] cnt;
    logic [`IMR_BAUD_W-1:0] baud;
    logic [`IMR_EV_W-1:0]   events;
    logic                   ack_data;
    logic                   is_rx;
    logic [3:0]             bitcnt;
    logic [7:0]             txbuf;
    logic [7:0]             shift;
    logic [7:0]             rxbuf;
    logic                   tx_buffer_full;
    logic                   transmit_in_progress;
    logic                   ackstat;
    logic                   start_seen;
    logic                   stop_seen;
    logic                   wcol;
    logic                   coll;
    logic                   irq;
    logic                   scl_oe;
    logic                   sda_oe;
    logic [31:0]            rdata;
  } imr_st_s;
endpackage

// ### src/imr_master.sv
// i2c master event sequencer: start, repeated start, stop, ack, byte tx/rx,
// clock synchronisation and arbitration with collision abort
// assumes open-drain scl/sda outside, pins asynchronous to sys_clk
// Operation
// - writing restart request bit 1 starts a repeated start
// - restart drives scl low, then once low releases sda for a baud period
// - after that period with sda high, release scl; reload baud once scl high
// - both lines high one baud period, then sda low one period, scl high
// - restart detected sets start-seen bit 3 and clears stop-seen bit 4
// - restart completion clears its request bit and raises master interrupt
// - transmit buffer write during restart is dropped and sets write collision
// - writes to five event bits ignored until the restart completes
// - event bits one-hot start restart stop rx ack; bit 14 shows transmitting
// - acknowledge event sends nack when ack data is one, else ack
// - clock sync and arbitration always active, no enable bit
// - baud counter holds until scl seen at the level its phase awaits (high or low), then reloads 9-bit value
// - in high phases scl low at rollover holds counter; rollover follows scl seen high
// - scl sampled once per clock cycle for synchronisation
// - expected sda high but low sets collision bit 10, interrupt, idle
// - arbitration checked in start, restart, address, data, ack, stop
// - collision in byte tx halts shifting, clears buffer full, frees lines
// - collision in start/restart/stop/ack aborts, clears request, frees lines; a start refused at its write leaves them as they were
// - ack data select at control bit 5 chooses ack or nack
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "imr_params.svh"

module imr_master
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             master_interrupt_request,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  imr_pkg::imr_st_s st_reg;
  imr_pkg::imr_st_s st_next;
  logic             scl_s;
  logic             sda_s;
  logic             is_hi;
  logic             expire;
  logic             chk_high;
  logic             collide;
  logic             busy;
  logic             done;
  logic [31:0]      ctrl_word;
  logic [31:0]      stat_word;

  // synchronised pins: only the second stage is read by logic
  assign scl_s = st_reg.scl_sync[1];
  assign sda_s = st_reg.sda_sync[1];
  assign busy  = (st_reg.state != imr_pkg::S_IDLE);

  // phases in which the counter waits for scl high before it runs
  always_comb
  begin
    case (st_reg.state)
      imr_pkg::S_HI_CHK, imr_pkg::S_SDA_LO, imr_pkg::S_P_HI,
      imr_pkg::S_P_END, imr_pkg::S_A_HI, imr_pkg::S_D_HI: is_hi = 1'b1;
      default: is_hi = 1'b0;
    endcase
  end

  // rollover only with scl seen high in high phases (clock stretch hold)
  assign expire = st_reg.seen && (st_reg.cnt == `IMR_BAUD_W'h0)
                  && (!is_hi || scl_s);

  // phases where our sda is released and the line must read high
  always_comb
  begin
    case (st_reg.state)
      imr_pkg::S_HI_CHK: chk_high = st_reg.seen;
      imr_pkg::S_P_END:  chk_high = st_reg.seen;
      imr_pkg::S_A_HI:   chk_high = st_reg.seen && st_reg.ack_data;
      imr_pkg::S_D_HI:   chk_high = st_reg.seen && !st_reg.is_rx
                                    && (st_reg.bitcnt < `IMR_BIT_LAST_TX)
                                    && st_reg.txbuf[3'h7 - st_reg.bitcnt[2:0]];
      default:           chk_high = 1'b0;
    endcase
  end

  // arbitration runs in the high-check phases listed above, nothing to enable it
  assign collide = chk_high && !sda_s;

  assign ctrl_word = {26'h0, st_reg.ack_data, st_reg.events};
  assign stat_word = {16'h0, st_reg.ackstat, st_reg.transmit_in_progress, 3'h0, st_reg.coll,
                      2'h0, st_reg.wcol, 2'h0, st_reg.stop_seen,
                      st_reg.start_seen, 2'h0, st_reg.tx_buffer_full};

  // whole next-state computation
  always_comb
  begin
    st_next          = st_reg;
    done             = 1'b0;
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.sda_prev = sda_s;
    st_next.irq      = 1'b0;
    st_next.rdata    = 32'h0;

    // baud generator: arm on the awaited scl level, then count down
    if (busy)
    begin
      if (!st_reg.seen)
      begin
        if (scl_s == is_hi)
        begin
          st_next.seen = 1'b1;
          st_next.cnt  = st_reg.baud;
        end
      end
      else if (st_reg.cnt != `IMR_BAUD_W'h0)
      begin
        st_next.cnt = st_reg.cnt - `IMR_BAUD_W'h1;
      end
    end

    // sequencer
    case (st_reg.state)
      imr_pkg::S_IDLE:
      begin
        // lines keep their level between events: releasing sda here with
        // scl high would put a false stop on the bus after a start
        st_next.scl_oe = st_reg.scl_oe;
        st_next.sda_oe = st_reg.sda_oe;
      end
      imr_pkg::S_RS_LO:
      begin
        st_next.scl_oe = 1'b1;
        if (!st_reg.seen && !scl_s)
          st_next.sda_oe = 1'b0;
        if (expire)
        begin
          st_next.seen = 1'b0;
          if (sda_s)
          begin
            st_next.scl_oe = 1'b0;
            st_next.state  = imr_pkg::S_HI_CHK;
          end
          else
            done = 1'b1; // collision handled below
        end
      end
      imr_pkg::S_HI_CHK:
      begin
        st_next.scl_oe = 1'b0;
        if (expire)
        begin
          st_next.sda_oe = 1'b1;
          st_next.seen   = 1'b0;
          st_next.state  = imr_pkg::S_SDA_LO;
        end
      end
      imr_pkg::S_SDA_LO:
      begin
        if (expire)
          done = 1'b1;
      end
      imr_pkg::S_P_LO:
      begin
        st_next.scl_oe = 1'b1;
        if (!st_reg.seen && !scl_s)
          st_next.sda_oe = 1'b1;
        if (expire)
        begin
          st_next.scl_oe = 1'b0;
          st_next.seen   = 1'b0;
          st_next.state  = imr_pkg::S_P_HI;
        end
      end
      imr_pkg::S_P_HI:
      begin
        if (expire)
        begin
          st_next.sda_oe = 1'b0;
          st_next.seen   = 1'b0;
          st_next.state  = imr_pkg::S_P_END;
        end
      end
      imr_pkg::S_P_END:
      begin
        if (expire)
          done = 1'b1;
      end
      imr_pkg::S_A_LO:
      begin
        st_next.scl_oe = 1'b1;
        if (!st_reg.seen && !scl_s)
          st_next.sda_oe = !st_reg.ack_data;
        if (expire)
        begin
          st_next.scl_oe = 1'b0;
          st_next.seen   = 1'b0;
          st_next.state  = imr_pkg::S_A_HI;
        end
      end
      imr_pkg::S_A_HI:
      begin
        if (expire)
        begin
          st_next.scl_oe = 1'b1;
          done           = 1'b1;
        end
      end
      imr_pkg::S_D_LO:
      begin
        st_next.scl_oe = 1'b1;
        // change sda only after scl really is low
        if (!st_reg.seen && !scl_s)
          st_next.sda_oe = !st_reg.is_rx && (st_reg.bitcnt < `IMR_BIT_LAST_TX)
                           && !st_reg.txbuf[3'h7 - st_reg.bitcnt[2:0]];
        if (expire)
        begin
          st_next.scl_oe = 1'b0;
          st_next.seen   = 1'b0;
          st_next.state  = imr_pkg::S_D_HI;
        end
      end
      imr_pkg::S_D_HI:
      begin
        if (expire)
        begin
          st_next.scl_oe = 1'b1;
          st_next.seen   = 1'b0;
          st_next.bitcnt = st_reg.bitcnt + 4'h1;
          st_next.state  = imr_pkg::S_D_LO;
          if (st_reg.bitcnt == `IMR_BIT_LAST_TX)
          begin
            st_next.ackstat = sda_s;
            done            = 1'b1;
          end
          else
          begin
            st_next.shift = {st_reg.shift[6:0], sda_s};
            if (st_reg.bitcnt == `IMR_BIT_LAST_DATA)
            begin
              st_next.tx_buffer_full = 1'b0;
              if (st_reg.is_rx)
              begin
                st_next.rxbuf = {st_reg.shift[6:0], sda_s};
                done          = 1'b1;
              end
            end
          end
        end
      end
      default:
        st_next.state = imr_pkg::S_IDLE;
    endcase

    // event end or arbitration loss: back to idle, request cleared
    if (done || collide)
    begin
      st_next.state  = imr_pkg::S_IDLE;
      st_next.seen   = 1'b0;
      st_next.events = `IMR_EV_W'h0;
      st_next.transmit_in_progress = 1'b0;
      st_next.irq    = 1'b1;
      if (!done || st_reg.state == imr_pkg::S_RS_LO)
      begin
        st_next.coll   = 1'b1;
        st_next.tx_buffer_full    = 1'b0;
        st_next.scl_oe = 1'b0;
        st_next.sda_oe = 1'b0;
      end
    end

    // start and stop seen on the bus, ours included
    if (scl_s && st_reg.sda_prev && !sda_s)
    begin
      st_next.start_seen = 1'b1;
      st_next.stop_seen  = 1'b0;
    end
    if (scl_s && !st_reg.sda_prev && sda_s)
    begin
      st_next.stop_seen  = 1'b1;
      st_next.start_seen = 1'b0;
    end

    // register writes; event bits only while the master is idle
    if (reg_wr)
    begin
      case (reg_addr)
        `IMR_OFF_CTRL:
        begin
          st_next.ack_data = reg_wdata[`IMR_CTL_ACKDATA];
          if (!busy)
          begin
            // one event only; lowest set bit wins, nothing queued
            if (reg_wdata[`IMR_CTL_START])
            begin
              st_next.events = `IMR_EV_W'h1 << `IMR_CTL_START;
              st_next.state  = (scl_s && sda_s) ? imr_pkg::S_HI_CHK : st_reg.state;
              st_next.coll   = st_reg.coll | !(scl_s && sda_s);
              st_next.irq    = !(scl_s && sda_s);
              if (!(scl_s && sda_s))
                st_next.events = `IMR_EV_W'h0;
            end
            else if (reg_wdata[`IMR_CTL_RESTART])
            begin
              st_next.events = `IMR_EV_W'h1 << `IMR_CTL_RESTART;
              st_next.state  = imr_pkg::S_RS_LO;
            end
            else if (reg_wdata[`IMR_CTL_STOP])
            begin
              st_next.events = `IMR_EV_W'h1 << `IMR_CTL_STOP;
              st_next.state  = imr_pkg::S_P_LO;
            end
            else if (reg_wdata[`IMR_CTL_RECV])
            begin
              st_next.events = `IMR_EV_W'h1 << `IMR_CTL_RECV;
              st_next.state  = imr_pkg::S_D_LO;
              st_next.is_rx  = 1'b1;
              st_next.bitcnt = 4'h0;
            end
            else if (reg_wdata[`IMR_CTL_ACK])
            begin
              st_next.events = `IMR_EV_W'h1 << `IMR_CTL_ACK;
              st_next.state  = imr_pkg::S_A_LO;
            end
          end
        end
        `IMR_OFF_STAT:
        begin
          // write zero clears, except coll while in S_RS_LO; a same-cycle hardware set wins
          if (!reg_wdata[`IMR_ST_WCOL])
            st_next.wcol = 1'b0;
          if (!reg_wdata[`IMR_ST_COLL] && !(collide || (done && !busy)))
            st_next.coll = st_next.coll & (collide | st_reg.state == imr_pkg::S_RS_LO);
        end
        `IMR_OFF_TXBUF:
        begin
          if (busy)
            st_next.wcol = 1'b1;
          else
          begin
            st_next.txbuf  = reg_wdata[7:0];
            st_next.tx_buffer_full    = 1'b1;
            st_next.transmit_in_progress = 1'b1;
            st_next.is_rx  = 1'b0;
            st_next.bitcnt = 4'h0;
            st_next.state  = imr_pkg::S_D_LO;
          end
        end
        `IMR_OFF_BAUD:
          st_next.baud = reg_wdata[`IMR_BAUD_W-1:0];
        default: ;
      endcase
    end

    // read data stands one cycle after the strobe, zero otherwise
    if (reg_rd)
    begin
      case (reg_addr)
        `IMR_OFF_CTRL:  st_next.rdata = ctrl_word;
        `IMR_OFF_STAT:  st_next.rdata = stat_word;
        `IMR_OFF_TXBUF: st_next.rdata = {24'h0, st_reg.txbuf};
        `IMR_OFF_BAUD:  st_next.rdata = {23'h0, st_reg.baud};
        `IMR_OFF_RXBUF: st_next.rdata = {24'h0, st_reg.rxbuf};
        default:        st_next.rdata = 32'h0;
      endcase
    end
  end

  // single state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_reg          <= '0;
      st_reg.scl_sync <= 2'h3;
      st_reg.sda_sync <= 2'h3;
      st_reg.sda_prev <= 1'b1;
      st_reg.state    <= imr_pkg::S_IDLE;
      st_reg.baud     <= `IMR_BAUD_RST;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata                = st_reg.rdata;
  assign master_interrupt_request = st_reg.irq;
  assign scl_oe                   = st_reg.scl_oe;
  assign sda_oe                   = st_reg.sda_oe;
  assign scl_out                  = 1'b0; // open drain: only ever pulls low
  assign sda_out                  = 1'b0;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_restart_entry: assert property ($rose(st_reg.events[`IMR_CTL_RESTART])
    |=> scl_oe) else $error("restart did not pull scl low");
  a_rs_release_sda: assert property (st_reg.state == imr_pkg::S_RS_LO && st_reg.seen
    |-> !sda_oe) else $error("sda held during restart low phase");
  a_rs_scl_free: assert property (st_reg.state == imr_pkg::S_HI_CHK
    |-> !scl_oe) else $error("scl driven in high check");
  a_sda_low_hi: assert property (st_reg.state == imr_pkg::S_SDA_LO
    |-> sda_oe && !scl_oe) else $error("start edge shape wrong");
  a_start_flags: assert property (scl_s && $past(sda_s) && !sda_s
    |=> st_reg.start_seen && !st_reg.stop_seen) else $error("start flags");
  a_done_clears: assert property (busy && done
    |=> st_reg.events == `IMR_EV_W'h0 && master_interrupt_request)
    else $error("event not retired");
  a_wcol_busy: assert property (busy && reg_wr && reg_addr == `IMR_OFF_TXBUF
    |=> st_reg.wcol && $stable(st_reg.txbuf)) else $error("tx write not dropped");
  a_events_locked: assert property (busy && !done && !collide
    |=> $stable(st_reg.events)) else $error("event bits changed while busy");
  a_onehot: assert property ($onehot0(st_reg.events))
    else $error("event bits not one-hot");
  a_ack_level: assert property (st_reg.state == imr_pkg::S_A_HI
    |-> sda_oe == !st_reg.ack_data) else $error("ack level wrong");
  a_hold_low: assert property (busy && is_hi && st_reg.seen && !scl_s
    && st_reg.cnt == `IMR_BAUD_W'h0 |=> $stable(st_reg.state))
    else $error("rollover with scl low");
  a_collision: assert property (collide |=> st_reg.coll && !scl_oe && !sda_oe
    && !st_reg.tx_buffer_full && st_reg.state == imr_pkg::S_IDLE)
    else $error("collision abort wrong");

  c_restart_done: cover property (st_reg.state == imr_pkg::S_SDA_LO && done
    && st_reg.events[`IMR_CTL_RESTART]);
  c_collision: cover property (collide);
  c_byte_sent: cover property (done && st_reg.state == imr_pkg::S_D_HI && !st_reg.is_rx);
  c_stretch: cover property (is_hi && st_reg.seen && !scl_s);
endmodule
`default_nettype wire

// ### verification/imr_bus_peer.sv
// peer on the shared bus: a slow slave that stretches scl and a rival master on sda
// assumes open-drain wires with pull-ups; the bench resolves the wire levels
`timescale 1ns/10ps
`default_nettype none

module imr_bus_peer
(
  input  wire logic       link_clk,
  input  wire logic [7:0] stretch_len,
  input  wire logic       grab_sda,
  input  wire logic       scl_wire,
  output logic            scl_pull,
  output logic            sda_pull
);
  logic       scl_d = 1'b1;
  logic [7:0] hold  = 8'h00;

  // every scl fall is held low for stretch_len peer cycles, like a slow slave
  always @(posedge link_clk)
  begin
    scl_d <= scl_wire;
    if (scl_d && !scl_wire)
      hold <= stretch_len;
    else if (hold != 8'h00)
      hold <= hold - 8'h01;
  end

  // pull only, never drive high: the pull-up restores the line on release
  assign scl_pull = (hold != 8'h00);
  // a rival master winning arbitration holds sda low
  assign sda_pull = grab_sda;
endmodule

`default_nettype wire

// ### verification/imr_master_tb.sv
// self-checking bench of the i2c master sequencer over its register port
// assumes imr_bus_peer on the bus and pull-ups on both wires
`timescale 1ns/10ps
`default_nettype none
`include "imr_params.svh"

module imr_master_tb;
  logic        sys_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        link_clk    = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_pull;
  logic        sda_pull;
  logic        scl_o;
  logic        sda_o;
  logic [7:0]  stretch     = 8'h00;
  logic        grab        = 1'b0;
  wire logic   scl_w;
  wire logic   sda_w;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          n0;
  int          n;
  int          lo;

  // wired-and bus: any enabled puller wins, else the pull-up
  assign scl_w = !(scl_oe | scl_pull);
  assign sda_w = !(sda_oe | sda_pull);

  // system clock 125 MHz
  initial
  begin
    forever #4 sys_clk = !sys_clk;
  end

  // peer clock 64 ns, phase offset from the system clock
  initial
  begin
    #5;
    forever #32 link_clk = !link_clk;
  end

  imr_master i_dut
  (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .master_interrupt_request (irq),
    .scl_in                   (scl_w),
    .scl_out                  (scl_o),
    .scl_oe                   (scl_oe),
    .sda_in                   (sda_w),
    .sda_out                  (sda_o),
    .sda_oe                   (sda_oe)
  );

  imr_bus_peer i_peer
  (
    .link_clk    (link_clk),
    .stretch_len (stretch),
    .grab_sda    (grab),
    .scl_wire    (scl_w),
    .scl_pull    (scl_pull),
    .sda_pull    (sda_pull)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after the strobe so back-to-back writes never reassign it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    cmp(reg_rdata & m, e);
  endtask

  // bounded wait for the event interrupt; low counts sda pulled under a high scl
  task automatic wait_irq(output int cyc, output int low);
    cyc = 0;
    low = 0;
    while (irq !== 1'b1 && cyc < 2000)
    begin
      @(posedge sys_clk);
      cyc++;
      if (sda_oe === 1'b1 && scl_w === 1'b1)
        low++;
    end
    cmp({31'h0, irq}, 32'h1);
  endtask

  // hang guard, far above the fewer than 2000 cycles the sequence needs
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    complete_run;
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdc(`IMR_OFF_CTRL, 32'h3f, 32'h0);
    rdc(`IMR_OFF_BAUD, 32'h1ff, 32'h0ff);
    rdc(8'h40, 32'hffffffff, 32'h0);
    wr(`IMR_OFF_BAUD, 32'h00f);
    rdc(`IMR_OFF_BAUD, 32'h1ff, 32'h00f);
    // start, then a repeated start with writes thrown at it mid-way
    wr(`IMR_OFF_CTRL, 32'h01);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h01);
    wait_irq(n, lo);
    rdc(`IMR_OFF_STAT, 32'h18, 32'h08);
    wr(`IMR_OFF_CTRL, 32'h02);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h02);
    wr(`IMR_OFF_CTRL, 32'h04);
    wr(`IMR_OFF_TXBUF, 32'h5a);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h02);
    wait_irq(n0, lo);
    cmp({31'h0, lo inside {[15:19]}}, 32'h1);
    cmp({30'h0, sda_oe, scl_oe}, 32'h2);
    cmp({30'h0, scl_o, sda_o}, 32'h0);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h0);
    rdc(`IMR_OFF_STAT, 32'h99, 32'h88);
    wr(`IMR_OFF_STAT, 32'h0);
    // the peer stretches scl: the high phase must wait for it
    stretch <= 8'h14;
    wr(`IMR_OFF_CTRL, 32'h02);
    wait_irq(n, lo);
    cmp({31'h0, n > n0 + 100}, 32'h1);
    cmp({31'h0, lo inside {[15:19]}}, 32'h1);
    stretch <= 8'h00;
    // rival master holds sda low during the high check
    wr(`IMR_OFF_CTRL, 32'h02);
    repeat (30) @(posedge sys_clk);
    grab <= 1'b1;
    wait_irq(n, lo);
    rdc(`IMR_OFF_STAT, 32'h400, 32'h400);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h0);
    cmp({30'h0, sda_oe, scl_oe}, 32'h0);
    wr(`IMR_OFF_STAT, 32'h0);
    // start onto a busy bus collides at once
    wr(`IMR_OFF_CTRL, 32'h01);
    wait_irq(n, lo);
    cmp({31'h0, n < 8}, 32'h1);
    rdc(`IMR_OFF_STAT, 32'h400, 32'h400);
    grab <= 1'b0;
    wr(`IMR_OFF_STAT, 32'h0);
    rdc(`IMR_OFF_STAT, 32'h400, 32'h0);
    // resend from a start, then close with a stop
    wr(`IMR_OFF_CTRL, 32'h01);
    wait_irq(n, lo);
    wr(`IMR_OFF_CTRL, 32'h04);
    rdc(`IMR_OFF_CTRL, 32'h1f, 32'h04);
    wait_irq(n, lo);
    rdc(`IMR_OFF_STAT, 32'h18, 32'h10);
    // byte lost to a rival master mid-transmit
    wr(`IMR_OFF_CTRL, 32'h01);
    wait_irq(n, lo);
    wr(`IMR_OFF_TXBUF, 32'hff);
    rdc(`IMR_OFF_STAT, 32'h4001, 32'h4001);
    grab <= 1'b1;
    wait_irq(n, lo);
    rdc(`IMR_OFF_STAT, 32'h4401, 32'h0400);
    cmp({30'h0, sda_oe, scl_oe}, 32'h0);
    grab <= 1'b0;
    wr(`IMR_OFF_STAT, 32'h0);
    // receive a byte, then answer ack and nack in turn
    wr(`IMR_OFF_CTRL, 32'h01);
    wait_irq(n, lo);
    for (int i = 0; i < 2; i++)
    begin
      wr(`IMR_OFF_CTRL, 32'h08);
      rdc(`IMR_OFF_CTRL, 32'h1f, 32'h08);
      wait_irq(n, lo);
      rdc(`IMR_OFF_RXBUF, 32'hff, 32'hff);
      wr(`IMR_OFF_CTRL, {26'h0, i[0], 5'h10});
      rdc(`IMR_OFF_CTRL, 32'h1f, 32'h10);
      wait_irq(n, lo);
      cmp({31'h0, (i == 1) ? (lo == 0) : (lo >= 15)}, 32'h1);
    end
    complete_run;
  end
endmodule

`default_nettype wire
